/* File: rtl/spd_pkg.sv */
// spd_pkg: constants and types shared by the pin direction block
// assumes a 32-bit AHB-Lite register bus and a separate link clock
package spd_pkg;
  // number of target select outputs unless overridden
  localparam int SPD_NSEL_DEF = 4;
  // register byte offsets, low address bits only
  localparam int SPD_AW = 8;
  localparam logic [7:0] SPD_CTRL_OFS = 8'h00;
  localparam logic [7:0] SPD_DRIVE_OFS = 8'h04;
  localparam logic [7:0] SPD_STATUS_OFS = 8'h08;
  // control register fields
  localparam int SPD_RUN_BIT = 8;
  localparam int SPD_SEL_LSB = 16;
  // drive register fields
  localparam int SPD_DVAL_LSB = 0;
  localparam int SPD_RDYV_BIT = 4;
  // status register fields
  localparam int SPD_FAULT_BIT = 0;
  localparam int SPD_PINS_LSB = 1;
  localparam int SPD_NPINS = 7;
  // values after reset
  localparam logic [31:0] SPD_CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] SPD_DVAL_RST = 4'hF;
  localparam logic SPD_RDYV_RST = 1'b1;
  // lane width modes
  typedef enum logic [1:0] {
    SPD_STD = 2'b00,
    SPD_DUAL = 2'b01,
    SPD_QUAD = 2'b10
  } spd_width_e;
  // control bits 8..0, en at bit 0
  typedef struct packed {
    logic sck_run;
    logic dir_out;
    logic fde;
    logic rdy_en;
    logic open_drain_output_mode;
    spd_width_e width;
    logic master;
    logic en;
  } spd_cfg_s;
endpackage

/* File: rtl/spd_cross_if.sv */
// spd_cross_if: signals between the bus side and the link side
// assumes hside drives levels on hclk, lside synchronises them
interface spd_cross_if
  import spd_pkg::*;
#(parameter int NSEL = SPD_NSEL_DEF);
  spd_cfg_s cfg;
  logic [NSEL-1:0] sel;
  logic [3:0] dval;
  logic rdy_val;
  logic clr_tgl;
  logic fault_tgl;
  logic lk_rst_n;
  modport hside(output cfg, sel, dval, rdy_val, clr_tgl,
    input fault_tgl, lk_rst_n);
  modport lside(input cfg, sel, dval, rdy_val, clr_tgl,
    output fault_tgl, lk_rst_n);
endinterface

/* File: rtl/spd_link.sv */
// spd_link: pin drivers and enables on the link clock
// assumes config levels arrive unsynchronised from the bus domain
module spd_link
  import spd_pkg::*;
#(parameter int NSEL = SPD_NSEL_DEF)
(
  input wire logic link_clk,
  input wire logic hresetn,
  spd_cross_if.lside cx,
  input wire logic select_input_n,
  input wire logic rdy_i,
  output logic sck_o,
  output logic sck_oen,
  output logic mosi_o,
  output logic mosi_oen,
  output logic miso_o,
  output logic miso_oen,
  output logic quad_data_two_o,
  output logic quad_data_two_oen,
  output logic quad_data_three_o,
  output logic quad_data_three_oen,
  output logic rdy_o,
  output logic rdy_oen,
  output logic [NSEL-1:0] target_select_out_n
);
  logic rs1, rst_n;
  spd_cfg_s cfg_s1, cfg_s2, cfg_s3, cfg;
  logic [NSEL-1:0] sel_s1, sel_s2, sel_s3, sel;
  logic [4:0] dv_s1, dv_s2, dv_s3, dv;
  logic [2:0] clr_s;
  logic ss_s1, ss_s2, rdy_s1, rdy_s2;
  logic fault_hold, fault_tgl, detect;
  logic act, mst, chosen, wide, lane_out, next_sck;

  // open drain only pulls low, otherwise drive the value
  function automatic logic [1:0] pin_drive(input logic en,
    input logic val, input logic drain);
    if (drain) pin_drive = {1'b0, !(en && !val)};
    else pin_drive = {val, !en};
  endfunction

  // reset asserts at once, releases on the link clock
  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      rs1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1 <= 1'b1;
      rst_n <= rs1;
    end
  end
  assign cx.lk_rst_n = rst_n;
  assign cx.fault_tgl = fault_tgl;

  // two-stage synchronisers; a config word is taken only when two
  // samples agree, so a bit mix caught mid-write never reaches the pins
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      {cfg_s1, cfg_s2, cfg_s3, cfg} <= '0;
      {sel_s1, sel_s2, sel_s3, sel, dv_s1, dv_s2, dv_s3, dv} <= '0;
      clr_s <= '0;
      {ss_s1, ss_s2, rdy_s1, rdy_s2} <= 4'hF;
    end else begin
      cfg_s1 <= cx.cfg;
      cfg_s2 <= cfg_s1;
      cfg_s3 <= cfg_s2;
      if (cfg_s3 == cfg_s2) cfg <= cfg_s2;
      sel_s1 <= cx.sel;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      if (sel_s3 == sel_s2) sel <= sel_s2;
      dv_s1 <= {cx.rdy_val, cx.dval};
      dv_s2 <= dv_s1;
      dv_s3 <= dv_s2;
      if (dv_s3 == dv_s2) dv <= dv_s2;
      clr_s <= {clr_s[1:0], cx.clr_tgl};
      ss_s1 <= select_input_n;
      ss_s2 <= ss_s1;
      rdy_s1 <= rdy_i;
      rdy_s2 <= rdy_s1;
    end
  end

  // a second master pulling the select low while we are master
  assign detect = cfg.en && cfg.master && cfg.fde && !ss_s2;

  // hold off the bus until software clears; a new fault wins
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_hold <= 1'b0;
      fault_tgl <= 1'b0;
    end else begin
      if (detect) fault_hold <= 1'b1;
      else if (clr_s[2] ^ clr_s[1]) fault_hold <= 1'b0;
      if (detect && !fault_hold) fault_tgl <= !fault_tgl;
    end
  end

  // role and direction of each lane
  always_comb begin
    act = cfg.en && !fault_hold && !detect;
    mst = act && cfg.master;
    chosen = act && !cfg.master && !ss_s2;
    wide = cfg.width == SPD_DUAL || cfg.width == SPD_QUAD;
    lane_out = wide && cfg.dir_out && (mst || chosen);
    // a low ready from the slave freezes the clock mid-bit
    if (!(mst && cfg.sck_run)) next_sck = 1'b0;
    else if (cfg.rdy_en && !rdy_s2) next_sck = sck_o;
    else next_sck = !sck_o;
  end

  // output flops, released after reset
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      {sck_o, mosi_o, miso_o, quad_data_two_o} <= 4'h0;
      {quad_data_three_o, rdy_o} <= 2'h0;
      {sck_oen, mosi_oen, miso_oen, quad_data_two_oen} <= 4'hF;
      {quad_data_three_oen, rdy_oen} <= 2'h3;
      target_select_out_n <= '1;
    end else begin
      sck_o <= next_sck;
      sck_oen <= !mst;
      {mosi_o, mosi_oen} <= pin_drive(wide ? lane_out : mst, dv[0],
        cfg.open_drain_output_mode);
      {miso_o, miso_oen} <= pin_drive(wide ? lane_out : chosen, dv[1],
        cfg.open_drain_output_mode);
      {quad_data_two_o, quad_data_two_oen} <= pin_drive(
        lane_out && cfg.width == SPD_QUAD, dv[2],
        cfg.open_drain_output_mode);
      {quad_data_three_o, quad_data_three_oen} <= pin_drive(
        lane_out && cfg.width == SPD_QUAD, dv[3],
        cfg.open_drain_output_mode);
      {rdy_o, rdy_oen} <= pin_drive(chosen && cfg.rdy_en, dv[4],
        1'b0);
      target_select_out_n <= mst ? ~sel : '1;
    end
  end

  sck_master_a: assert property (
    @(posedge link_clk) disable iff (!rst_n) mst |=> !sck_oen)
    else $error("clock not driven as master");
  sck_slave_a: assert property (
    @(posedge link_clk) disable iff (!rst_n) !cfg.master |=> sck_oen)
    else $error("clock driven as slave");
  rdy_stall_a: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    mst && cfg.sck_run && cfg.rdy_en && !rdy_s2
    |=> $stable(sck_o) && rdy_oen)
    else $error("clock moved while not ready");
  quad_lanes_a: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    cfg.width != SPD_QUAD |=> quad_data_two_oen && quad_data_three_oen)
    else $error("extra lanes driven outside quad");
  // open drain releases a high bit, so directions compare push-pull only
  lane_same_a: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    wide && !cfg.open_drain_output_mode |=> mosi_oen == miso_oen)
    else $error("wide lanes differ in direction");
  drain_low_a: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    cfg.open_drain_output_mode |=> !mosi_o && !miso_o
    && !quad_data_two_o && !quad_data_three_o)
    else $error("open drain drove high");
  sel_slave_a: assert property (
    @(posedge link_clk) disable iff (!rst_n) !mst |=> &target_select_out_n)
    else $error("select as non master");
  unsel_quiet_a: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    !cfg.master && ss_s2 |=> mosi_oen && miso_oen && rdy_oen)
    else $error("slave drove while not selected");
  fault_rel_a: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    detect && !fault_hold |=> sck_oen && mosi_oen && miso_oen
    && &target_select_out_n && fault_tgl != $past(fault_tgl))
    else $error("mode fault did not release bus");
endmodule // spd_link

/* File: rtl/spd_pin_ctrl.sv */
// spd_pin_ctrl: AHB-Lite registers for serial port pin direction
// assumes one AHB-Lite master, word accesses and a free link clock
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
module spd_pin_ctrl
  import spd_pkg::*;
#(parameter int NSEL = SPD_NSEL_DEF)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic link_clk,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oen,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oen,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oen,
  input wire logic quad_data_two_i,
  output logic quad_data_two_o,
  output logic quad_data_two_oen,
  input wire logic quad_data_three_i,
  output logic quad_data_three_o,
  output logic quad_data_three_oen,
  input wire logic rdy_i,
  output logic rdy_o,
  output logic rdy_oen,
  input wire logic select_input_n,
  output logic [NSEL-1:0] target_select_out_n
);
  spd_cross_if #(.NSEL(NSEL)) cx ();

  // bus pipeline state
  logic acc;
  logic wr_pend;
  logic rd_pend;
  logic [SPD_AW-1:0] addr_q;

  // software registers
  spd_cfg_s cfg_q;
  logic [NSEL-1:0] sel_q;
  logic [3:0] dval_q;
  logic rdyv_q;
  logic fault_flag;
  logic clr_tgl;
  logic wr_status_clr;

  // crossings from the link and the pins
  logic [2:0] ft_s;
  logic fault_evt;
  logic [1:0] lk_s;
  logic [SPD_NPINS-1:0] pin_s1;
  logic [SPD_NPINS-1:0] pin_s2;
  logic [31:0] next_rdata;

  // address phase is taken only while the bus is ready
  assign acc = hsel && htrans[1] && hready;

  // hsize is ignored: every register is one whole word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= '0;
    end else begin
      wr_pend <= acc && hwrite;
      rd_pend <= acc && !hwrite;
      if (acc) begin
        addr_q <= haddr[SPD_AW-1:0];
      end
    end
  end

  // reads take one wait state so that a write just before is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(acc && !hwrite);
    end
  end

  // the response is always okay, unmapped offsets included
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // read data, zero at unmapped offsets and reserved bits
  always_comb begin
    next_rdata = '0;
    case (addr_q)
      SPD_CTRL_OFS: begin
        next_rdata[SPD_RUN_BIT:0] = cfg_q;
        next_rdata[SPD_SEL_LSB +: NSEL] = sel_q;
      end
      SPD_DRIVE_OFS: begin
        next_rdata[SPD_DVAL_LSB +: 4] = dval_q;
        next_rdata[SPD_RDYV_BIT] = rdyv_q;
      end
      SPD_STATUS_OFS: begin
        next_rdata[SPD_FAULT_BIT] = fault_flag;
        next_rdata[SPD_PINS_LSB +: SPD_NPINS] = pin_s2;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // hrdata is loaded during the wait state and held afterwards
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_pend) begin
      hrdata <= next_rdata;
    end
  end

  // control register; mode changes are meant to be made while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= spd_cfg_s'(SPD_CTRL_RST[SPD_RUN_BIT:0]);
      sel_q <= SPD_CTRL_RST[SPD_SEL_LSB +: NSEL];
    end else if (wr_pend && addr_q == SPD_CTRL_OFS) begin
      cfg_q <= spd_cfg_s'(hwdata[SPD_RUN_BIT:0]);
      sel_q <= hwdata[SPD_SEL_LSB +: NSEL];
    end
  end

  // drive values for data lanes and ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dval_q <= SPD_DVAL_RST;
      rdyv_q <= SPD_RDYV_RST;
    end else if (wr_pend && addr_q == SPD_DRIVE_OFS) begin
      dval_q <= hwdata[SPD_DVAL_LSB +: 4];
      rdyv_q <= hwdata[SPD_RDYV_BIT];
    end
  end

  // writing one to the fault bit clears it
  assign wr_status_clr = wr_pend && addr_q == SPD_STATUS_OFS
    && hwdata[SPD_FAULT_BIT];

  // fault event from the link domain arrives as a toggle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ft_s <= '0;
    end else begin
      ft_s <= {ft_s[1:0], cx.fault_tgl};
    end
  end
  assign fault_evt = ft_s[2] ^ ft_s[1];

  // link side reset state seen on the bus clock, for the checks below
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lk_s <= '0;
    end else begin
      lk_s <= {lk_s[0], cx.lk_rst_n};
    end
  end

  // sticky fault flag: an event in the clearing cycle still sets it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_flag <= 1'b0;
    end else begin
      fault_flag <= fault_evt || (fault_flag && !wr_status_clr);
    end
  end

  // the clear also releases the link side hold, sent as a toggle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clr_tgl <= 1'b0;
    end else if (wr_status_clr) begin
      clr_tgl <= !clr_tgl;
    end
  end

  // pin levels for software, two flops since pins are asynchronous
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {select_input_n, rdy_i, quad_data_three_i,
        quad_data_two_i, miso_i, mosi_i, sck_i};
      pin_s2 <= pin_s1;
    end
  end

  // levels handed to the link side
  assign cx.cfg = cfg_q;
  assign cx.sel = sel_q;
  assign cx.dval = dval_q;
  assign cx.rdy_val = rdyv_q;
  assign cx.clr_tgl = clr_tgl;

  // link side logic on its own clock
  spd_link #(.NSEL(NSEL)) u_link (
    .link_clk(link_clk),
    .hresetn(hresetn),
    .cx(cx),
    .select_input_n(select_input_n),
    .rdy_i(rdy_i),
    .sck_o(sck_o),
    .sck_oen(sck_oen),
    .mosi_o(mosi_o),
    .mosi_oen(mosi_oen),
    .miso_o(miso_o),
    .miso_oen(miso_oen),
    .quad_data_two_o(quad_data_two_o),
    .quad_data_two_oen(quad_data_two_oen),
    .quad_data_three_o(quad_data_three_o),
    .quad_data_three_oen(quad_data_three_oen),
    .rdy_o(rdy_o),
    .rdy_oen(rdy_oen),
    .target_select_out_n(target_select_out_n)
  );

  // a fault toggle seen on the bus side sets the flag next edge
  fault_flag_a: assert property (
    @(posedge hclk) disable iff (!hresetn) fault_evt |=> fault_flag)
    else $error("fault flag not set");

  // the flag stays until software writes one, absent new events
  fault_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fault_flag && !wr_status_clr |=> fault_flag)
    else $error("fault flag dropped without clear");

  // a clear with no event in the same cycle drops the flag
  fault_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_status_clr && !fault_evt |=> !fault_flag)
    else $error("fault flag not cleared");

  // every clear is passed to the link side as one toggle
  clear_send_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_status_clr |=> clr_tgl != $past(clr_tgl))
    else $error("clear not sent to link side");

  // no fault can come from a link side still held in reset
  link_live_a: assert property (
    @(posedge hclk) disable iff (!hresetn) !lk_s[1] |-> !fault_evt)
    else $error("fault seen while link side in reset");

  // a read answers after exactly one wait state
  read_wait_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  // a write answers at once, with no wait state
  write_nowait_a: assert property (
    @(posedge hclk) disable iff (!hresetn) acc && hwrite |=> hreadyout)
    else $error("write inserted a wait state");

  // a control write lands at the end of its data phase
  ctrl_store_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_pend && addr_q == SPD_CTRL_OFS
    |=> cfg_q == $past(hwdata[SPD_RUN_BIT:0])
    && sel_q == $past(hwdata[SPD_SEL_LSB +: NSEL]))
    else $error("control write lost");

  // a drive write lands the lane and ready values
  drive_store_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_pend && addr_q == SPD_DRIVE_OFS
    |=> dval_q == $past(hwdata[SPD_DVAL_LSB +: 4])
    && rdyv_q == $past(hwdata[SPD_RDYV_BIT]))
    else $error("drive write lost");

  // read data holds between reads
  rdata_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn) !rd_pend |=> $stable(hrdata))
    else $error("read data changed without a read");

  // status reads show the flag and the synchronised pin levels
  status_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_pend && addr_q == SPD_STATUS_OFS
    |=> hrdata[SPD_FAULT_BIT] == $past(fault_flag)
    && hrdata[SPD_PINS_LSB +: SPD_NPINS] == $past(pin_s2))
    else $error("status read wrong");

  // unmapped offsets read as zero
  unmapped_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_pend && addr_q != SPD_CTRL_OFS && addr_q != SPD_DRIVE_OFS
    && addr_q != SPD_STATUS_OFS |=> hrdata == 32'h0000_0000)
    else $error("unmapped offset read nonzero");

endmodule // spd_pin_ctrl

/* File: dv/spd_far_dev.sv */
// spd_far_dev: far side of the serial port, a peer master or slave
// assumes pull-ups on data lanes and ready, and the same link clock
module spd_far_dev (
  input wire logic link_clk,
  input wire logic ext_sel,
  input wire logic stall,
  input wire logic sck_o,
  input wire logic sck_oen,
  input wire logic [3:0] lane_o,
  input wire logic [3:0] lane_oen,
  input wire logic rdy_o,
  input wire logic rdy_oen,
  output logic sck_i,
  output logic [3:0] lane_i,
  output logic rdy_i,
  output logic select_input_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sck_ext = 1'b0;
  // a peer master clocks only while it selects us; idle clock stands at 0
  always @(posedge link_clk) begin
    sck_ext <= ext_sel ? ~sck_ext : 1'b0;
  end
  // a peer master or a rival master pulls the select low
  assign select_input_n = ~ext_sel;
  assign sck_i = sck_oen ? sck_ext : sck_o;
  // released lanes float up to the pull-up level
  assign lane_i = (lane_o & ~lane_oen) | lane_oen;
  // as a slave we throttle the master through ready
  assign rdy_i = rdy_oen ? ~stall : rdy_o;
endmodule // spd_far_dev

/* File: dv/tb_top.sv */
// tb_top: self-checking bench for the pin direction block
// assumes the far side model and a single AHB-Lite master here
module tb_top
  import spd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 1'b0;
  logic link_clk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ext_sel = 1'b0;
  logic stall = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, sck_i, sck_o, sck_oen, rdy_i, rdy_o, rdy_oen;
  logic seln, a;
  logic [3:0] lo, loe, li, tsel_n, dv, eoe;
  int n_mismatch = 0;
  int samples_checked = 0;
  int idx;

  always #2.5 hclk = ~hclk;
  // link clock period 64 ns, phase unrelated to the bus clock
  always #32 link_clk = ~link_clk;

  spd_pin_ctrl #(.NSEL(4)) spd_pin_ctrl_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk),
    .sck_i(sck_i), .sck_o(sck_o), .sck_oen(sck_oen), .mosi_i(li[0]),
    .mosi_o(lo[0]), .mosi_oen(loe[0]), .miso_i(li[1]), .miso_o(lo[1]),
    .miso_oen(loe[1]), .quad_data_two_i(li[2]), .quad_data_two_o(lo[2]),
    .quad_data_two_oen(loe[2]), .quad_data_three_i(li[3]),
    .quad_data_three_o(lo[3]), .quad_data_three_oen(loe[3]),
    .rdy_i(rdy_i), .rdy_o(rdy_o), .rdy_oen(rdy_oen),
    .select_input_n(seln), .target_select_out_n(tsel_n));

  spd_far_dev spd_far_dev_i (.link_clk(link_clk), .ext_sel(ext_sel),
    .stall(stall), .sck_o(sck_o), .sck_oen(sck_oen), .lane_o(lo),
    .lane_oen(loe), .rdy_o(rdy_o), .rdy_oen(rdy_oen), .sck_i(sck_i),
    .lane_i(li), .rdy_i(rdy_i), .select_input_n(seln));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one single transfer; a dead slave is left to the watchdog
  task automatic ahb(input logic w, input logic [7:0] ad,
    input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, ad};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // config crosses three sync flops and a hold register in the link domain, so give it room
  task automatic settle();
    repeat (8) @(posedge link_clk);
    @(posedge hclk);
  endtask

  function automatic logic [31:0] mk_ctrl(logic ms, logic [1:0] w,
    logic drain, logic rdy, logic fde, logic dir, logic run, logic [3:0] sel);
    spd_cfg_s cf;
    cf = '{run, dir, fde, rdy, drain, spd_width_e'(w), ms, 1'b1};
    return 32'(cf) | (32'(sel) << SPD_SEL_LSB);
  endfunction

  // lane enables as master, bits are d3, d2, miso, mosi
  function automatic logic [3:0] lane_oen(logic [1:0] w, logic dir,
    logic drain, logic [3:0] d);
    logic [3:0] b;
    case (w)
      2'b01: b = dir ? 4'hC : 4'hF;
      2'b10: b = dir ? 4'h0 : 4'hF;
      default: b = 4'hE;
    endcase
    return drain ? (b | d) : b;
  endfunction

  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h38815A48));
    repeat (3) @(posedge link_clk);
    @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk("tsel", 32'hF, {28'h0, tsel_n});
    chk("sck_oen", 32'h1, {31'h0, sck_oen});
    ahb(1'b0, SPD_CTRL_OFS, 32'h0, rd);
    chk("ctrl", SPD_CTRL_RST, rd);
    ahb(1'b0, SPD_DRIVE_OFS, 32'h0, rd);
    chk("drive", 32'h1F, rd & 32'h1F);
    ahb(1'b1, 8'h0C, $urandom, rd);
    ahb(1'b0, 8'h0C, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
    // every width, lane direction and drain mode as master
    for (int m = 0; m < 12; m++) begin
      idx = $urandom_range(3, 0);
      dv = 4'($urandom);
      ahb(1'b1, SPD_CTRL_OFS, 32'h0, rd);
      ahb(1'b1, SPD_DRIVE_OFS, {28'h0, dv}, rd);
      ahb(1'b1, SPD_CTRL_OFS, mk_ctrl(1'b1, 2'(m % 3), 1'(m / 6), 1'b0,
        1'b0, 1'((m / 3) % 2), 1'b1, 4'(4'h1 << idx)), rd);
      settle();
      eoe = lane_oen(2'(m % 3), 1'((m / 3) % 2), 1'(m / 6), dv);
      chk("lane_oen", {28'h0, eoe}, {28'h0, loe});
      chk("lane_o", {28'h0, dv & ~eoe}, {28'h0, lo & ~loe});
      chk("sck_oen", 32'h0, {31'h0, sck_oen});
      chk("tsel", {28'h0, 4'(~(4'h1 << idx))}, {28'h0, tsel_n});
      ahb(1'b0, SPD_STATUS_OFS, 32'h0, rd);
      chk("pins", {28'h0, eoe | dv}, {28'h0, rd[5:2]});
    end
    $display("test lanes done");
    // a stalling slave freezes the clock, release lets it run again
    ahb(1'b1, SPD_CTRL_OFS, 32'h0, rd);
    ahb(1'b1, SPD_CTRL_OFS, mk_ctrl(1'b1, 2'b00, 1'b0, 1'b1, 1'b0, 1'b0,
      1'b1, 4'h1), rd);
    stall <= 1'b1;
    settle();
    chk("rdy_oen", 32'h1, {31'h0, rdy_oen});
    @(posedge link_clk);
    #1 a = sck_o;
    repeat (4) @(posedge link_clk);
    #1 chk("sck_hold", {31'h0, a}, {31'h0, sck_o});
    @(posedge hclk);
    stall <= 1'b0;
    settle();
    @(posedge link_clk);
    #1 a = sck_o;
    @(posedge link_clk);
    #1 chk("sck_run", {31'h0, !a}, {31'h0, sck_o});
    $display("test ready done");
    // slave: a peer master selects us and we answer on miso and ready
    a = 1'($urandom);
    dv = 4'($urandom);
    ahb(1'b1, SPD_CTRL_OFS, 32'h0, rd);
    ahb(1'b1, SPD_DRIVE_OFS, {27'h0, a, dv}, rd);
    ahb(1'b1, SPD_CTRL_OFS, mk_ctrl(1'b0, 2'b00, 1'b0, 1'b1, 1'b0, 1'b0,
      1'b0, 4'h0), rd);
    ext_sel <= 1'b1;
    settle();
    chk("sck_oen", 32'h1, {31'h0, sck_oen});
    chk("miso_oen", 32'h0, {31'h0, loe[1]});
    chk("miso_o", {31'h0, dv[1]}, {31'h0, lo[1]});
    chk("mosi_oen", 32'h1, {31'h0, loe[0]});
    chk("rdy_oen", 32'h0, {31'h0, rdy_oen});
    chk("rdy_o", {31'h0, a}, {31'h0, rdy_o});
    chk("tsel", 32'hF, {28'h0, tsel_n});
    ahb(1'b0, SPD_STATUS_OFS, 32'h0, rd);
    chk("sel_in", 32'h0, {31'h0, rd[7]});
    ext_sel <= 1'b0;
    settle();
    chk("miso_rel", 32'h1, {31'h0, loe[1]});
    chk("rdy_rel", 32'h1, {31'h0, rdy_oen});
    $display("test slave done");
    // rival master: ignored unless watching, else release and flag
    for (int f = 0; f < 2; f++) begin
      ahb(1'b1, SPD_CTRL_OFS, 32'h0, rd);
      ahb(1'b1, SPD_CTRL_OFS, mk_ctrl(1'b1, 2'b00, 1'b0, 1'b0, 1'(f),
        1'b0, 1'b1, 4'h2), rd);
      ext_sel <= 1'b1;
      settle();
      chk("sck_oen", {31'h0, 1'(f)}, {31'h0, sck_oen});
      chk("tsel", f ? 32'hF : 32'hD, {28'h0, tsel_n});
      chk("mosi_oen", {31'h0, 1'(f)}, {31'h0, loe[0]});
      ahb(1'b0, SPD_STATUS_OFS, 32'h0, rd);
      chk("fault", {31'h0, 1'(f)}, {31'h0, rd[0]});
      ext_sel <= 1'b0;
      settle();
    end
    chk("fault_hold", 32'h1, {31'h0, sck_oen});
    ahb(1'b1, SPD_STATUS_OFS, 32'h1, rd);
    settle();
    ahb(1'b0, SPD_STATUS_OFS, 32'h0, rd);
    chk("fault_clr", 32'h0, {31'h0, rd[0]});
    chk("sck_back", 32'h0, {31'h0, sck_oen});
    $display("test fault done");
    print_verdict();
  end
endmodule // tb_top
